// ---- include/ptpfp_defs.svh ----
/*
 * Register offsets, field positions, reset values and stream constants of the PTP port frame processor.
 * Assumes byte addressing on a 32-bit APB with one aligned word per register.
 */
`ifndef PTPFP_DEFS_SVH
`define PTPFP_DEFS_SVH
`define PTPFP_OFS_CTRL 8'h00
`define PTPFP_OFS_MASK 8'h04
`define PTPFP_OFS_LAT 8'h08
`define PTPFP_OFS_FILT 8'h0C
`define PTPFP_OFS_DROP 8'h10
`define PTPFP_OFS_TS 8'h14
`define PTPFP_FLT_EN 0
`define PTPFP_MOD_EN 1
`define PTPFP_VER_EN 2
`define PTPFP_DOM_EN 3
`define PTPFP_ALT_EN 4
`define PTPFP_FCS_DIS 5
`define PTPFP_UDP_DIS 6
`define PTPFP_BAD_DIS 7
`define PTPFP_VER_LSB 8
`define PTPFP_DOM_LSB 16
`define PTPFP_CTRL_RST 32'h0000_0000
`define PTPFP_MASK_RST 16'h0000
`define PTPFP_LAT_RST 16'h0000
`define PTPFP_PREAMBLE 4'h5
`define PTPFP_SFD 4'hD
`define PTPFP_POLY 32'hEDB8_8320
`define PTPFP_CRC_INIT 32'hFFFF_FFFF
`define PTPFP_RESIDUE 32'hDEBB_20E3
`define PTPFP_CK_GOOD 16'hFFFF
`define PTPFP_FCS_NIBS 4'h8
`endif

// ---- include/ptpfp_pkg.sv ----
/*
 * Types of the PTP port frame processor: state encodings and the packed state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ptpfp_pkg;
    typedef enum logic [3:0] {R_IDLE = 4'h1, R_PRE = 4'h2, R_BODY = 4'h4, R_DRAIN = 4'h8} ptpfp_rx_type;
    typedef enum logic [2:0] {T_IDLE = 3'h1, T_PRE = 3'h2, T_BODY = 3'h4} ptpfp_tx_type;
    typedef struct packed {
        ptpfp_rx_type rx_st;
        ptpfp_tx_type tx_st;
        logic [7:0][3:0] line_d;
        logic [7:0] line_b;
        logic [7:0] line_e;
        logic [3:0] fill;
        logic [31:0] icrc;
        logic [31:0] ocrc;
        logic [15:0] acc;
        logic [15:0] vsum;
        logic [15:0] orig_ck;
        logic mod;
        logic v4;
        logic v6;
        logic hit;
        logic fcs_ok;
        logic f_drop;
        logic f_filt;
        logic [3:0] out_d;
        logic out_dv;
        logic out_er;
        logic [31:0] ctrl;
        logic [15:0] mask;
        logic [15:0] lat;
        logic [31:0] filt_cnt;
        logic [31:0] drop_cnt;
        logic [31:0] ts;
        logic ts_valid;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ptpfp_state_type;
endpackage : ptpfp_pkg

// ---- design/ptpfp_top.sv ----
/*
 * PTP port frame processor: receive nibble fix-up and filtering, transmit SFD timestamp, APB registers.
 * Assumes an upstream parser that flags PTP fields on the receive nibble stream, aligned with RXD.
 */
`include "ptpfp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ptpfp_top (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RX_DV,
    input wire logic [3:0] RXD,
    input wire logic RX_ER,
    input wire logic PTP_QUAL,
    input wire logic IS_V4,
    input wire logic IS_V6,
    input wire logic MOD_FRAME,
    input wire logic MOD_VALID,
    input wire logic [3:0] MOD_NIB,
    input wire logic CK_COVER,
    input wire logic CK_FIELD,
    input wire logic COMP_FIELD,
    input wire logic [1:0] NIB_IDX,
    input wire logic HDR_VALID,
    input wire logic [3:0] PTP_MSG_TYPE,
    input wire logic [3:0] PTP_VERSION,
    input wire logic [7:0] PTP_DOMAIN,
    input wire logic PTP_ALT_MASTER,
    output logic RXO_DV,
    output logic [3:0] RXO_D,
    output logic RXO_ER,
    input wire logic TX_EN,
    input wire logic [3:0] TXD,
    input wire logic [31:0] TOD,
    output logic [31:0] EGRESS_TS,
    output logic EGRESS_VALID
);
    localparam ptpfp_pkg::ptpfp_state_type S_RST = '{rx_st: ptpfp_pkg::R_IDLE, tx_st: ptpfp_pkg::T_IDLE,
        icrc: `PTPFP_CRC_INIT, ocrc: `PTPFP_CRC_INIT, ctrl: `PTPFP_CTRL_RST, mask: `PTPFP_MASK_RST,
        lat: `PTPFP_LAT_RST, default: '0};

    ptpfp_pkg::ptpfp_state_type s;
    ptpfp_pkg::ptpfp_state_type next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // End-around carry add used by checksum verification and compensation.
    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[15:0] + {15'h0000, t[16]};
    endfunction : oc_add

    // Places a nibble in its 16-bit word; low nibble of the high byte arrives first.
    function automatic logic [15:0] place(input logic [3:0] v, input logic [1:0] idx);
        case (idx)
            2'h0: place = {4'h0, v, 8'h00};
            2'h1: place = {v, 12'h000};
            2'h2: place = {12'h000, v};
            default: place = {8'h00, v, 4'h0};
        endcase
    endfunction : place

    // Advances the reflected Ethernet CRC by one nibble, lowest bit first.
    function automatic logic [31:0] crc4(input logic [31:0] c, input logic [3:0] v);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++) begin
            r = (r >> 1) ^ ((r[0] ^ v[i]) ? `PTPFP_POLY : 32'h0000_0000);
        end
        return r;
    endfunction : crc4

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic of bus slave, receive pipeline and transmit snapshot.
    always_comb begin
        logic [31:0] rd;
        logic ok;
        logic push;
        logic emit;
        logic modon;
        logic [3:0] nib;
        logic [15:0] w;
        logic fcs_pass;
        logic ck_pass;
        logic ck_ok;
        rd = 32'h0000_0000;
        ok = 1'b1;
        push = RX_DV && (s.rx_st != ptpfp_pkg::R_DRAIN);
        emit = 1'b0;
        modon = PTP_QUAL && s.ctrl[`PTPFP_MOD_EN] && MOD_FRAME;
        nib = RXD;
        w = 16'h0000;
        fcs_pass = 1'b0;
        ck_pass = 1'b0;
        ck_ok = 1'b0;
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.ts_valid = 1'b0;
        next_s.out_dv = 1'b0;
        next_s.out_er = 1'b0;

        // Register read decode; unmapped offsets answer with an error and zero data.
        case (PADDR)
            `PTPFP_OFS_CTRL: rd = s.ctrl;
            `PTPFP_OFS_MASK: rd = {16'h0000, s.mask};
            `PTPFP_OFS_LAT: rd = {16'h0000, s.lat};
            `PTPFP_OFS_FILT: rd = s.filt_cnt;
            `PTPFP_OFS_DROP: rd = s.drop_cnt;
            `PTPFP_OFS_TS: rd = s.ts;
            default: ok = 1'b0;
        endcase
        if (PSEL && PENABLE && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !ok;
            next_s.prdata = ok ? rd : 32'h0000_0000;
        end
        // Writes land at the completing edge only.
        if (PSEL && PENABLE && s.pready && PWRITE) begin
            case (PADDR)
                `PTPFP_OFS_CTRL: next_s.ctrl = {8'h00, PWDATA[23:16], 4'h0, PWDATA[11:0]};
                `PTPFP_OFS_MASK: next_s.mask = PWDATA[15:0];
                `PTPFP_OFS_LAT: next_s.lat = PWDATA[15:0];
                default: next_s.lat = s.lat;
            endcase
        end

        // Receive framing: start of frame clears per-frame state except fcs_ok, f_drop and f_filt, which are set at body end.
        case (s.rx_st)
            ptpfp_pkg::R_IDLE: begin
                if (RX_DV) begin
                    next_s.icrc = `PTPFP_CRC_INIT;
                    next_s.ocrc = `PTPFP_CRC_INIT;
                    next_s.acc = 16'h0000;
                    next_s.vsum = 16'h0000;
                    next_s.orig_ck = 16'h0000;
                    next_s.mod = 1'b0;
                    next_s.v4 = 1'b0;
                    next_s.v6 = 1'b0;
                    next_s.hit = 1'b0;
                    next_s.fill = 4'h0;
                    next_s.rx_st = (RXD == `PTPFP_SFD) ? ptpfp_pkg::R_BODY : ptpfp_pkg::R_PRE;
                end
            end
            ptpfp_pkg::R_PRE: begin
                if (!RX_DV) begin
                    next_s.rx_st = ptpfp_pkg::R_DRAIN;
                end else if (RXD == `PTPFP_SFD) begin
                    next_s.rx_st = ptpfp_pkg::R_BODY;
                end
            end
            ptpfp_pkg::R_BODY: begin
                if (!RX_DV) begin
                    next_s.rx_st = ptpfp_pkg::R_DRAIN;
                    next_s.fcs_ok = s.icrc == `PTPFP_RESIDUE;
                    fcs_pass = s.ctrl[`PTPFP_FCS_DIS] || (s.icrc == `PTPFP_RESIDUE);
                    ck_ok = (s.vsum == `PTPFP_CK_GOOD) && (s.v4 ? 1'b1 : (s.orig_ck != 16'h0000));
                    ck_ok = ck_ok || (s.v4 && (s.orig_ck == 16'h0000));
                    ck_pass = s.ctrl[`PTPFP_UDP_DIS] || !(s.v4 || s.v6) || ck_ok;
                    next_s.f_drop = s.mod && !ck_pass && !s.ctrl[`PTPFP_BAD_DIS];
                    next_s.f_filt = s.hit && fcs_pass && ck_pass;
                end
            end
            ptpfp_pkg::R_DRAIN: begin
                if (s.fill <= 4'h1) begin
                    next_s.rx_st = ptpfp_pkg::R_IDLE;
                end
            end
            default: next_s.rx_st = ptpfp_pkg::R_IDLE;
        endcase

        // Per-nibble work on the frame body.
        if (push && (s.rx_st == ptpfp_pkg::R_BODY)) begin
            next_s.icrc = crc4(s.icrc, RXD);
            next_s.mod = s.mod || modon;
            next_s.v4 = s.v4 || (PTP_QUAL && IS_V4);
            next_s.v6 = s.v6 || (PTP_QUAL && IS_V6);
            if (CK_COVER) begin
                next_s.vsum = oc_add(s.vsum, place(RXD, NIB_IDX));
            end
            if (CK_FIELD) begin
                next_s.orig_ck = s.orig_ck | place(RXD, NIB_IDX);
                if (modon && IS_V4) begin
                    nib = 4'h0;
                end
            end
            if (modon && MOD_VALID) begin
                next_s.acc = oc_add(oc_add(s.acc, place(RXD, NIB_IDX)), ~place(MOD_NIB, NIB_IDX));
                nib = MOD_NIB;
            end
            if (HDR_VALID && PTP_QUAL && s.ctrl[`PTPFP_FLT_EN]) begin
                next_s.hit = s.hit || s.mask[PTP_MSG_TYPE]
                    || (s.ctrl[`PTPFP_VER_EN] && (s.ctrl[11:8] != 4'h0) && (PTP_VERSION != s.ctrl[11:8]))
                    || (s.ctrl[`PTPFP_DOM_EN] && (PTP_DOMAIN != s.ctrl[23:16]))
                    || (s.ctrl[`PTPFP_ALT_EN] && PTP_ALT_MASTER);
            end
        end

        // Delay line of eight nibbles keeps the FCS behind the frame end.
        if (push) begin
            next_s.line_d = {s.line_d[6:0], nib};
            next_s.line_b = {s.line_b[6:0], s.rx_st == ptpfp_pkg::R_BODY};
            next_s.line_e = {s.line_e[6:0], RX_ER};
            if (s.fill == `PTPFP_FCS_NIBS) begin
                emit = 1'b1;
            end else begin
                next_s.fill = s.fill + 4'h1;
            end
            // compensation word completes at its last nibble.
            if ((s.rx_st == ptpfp_pkg::R_BODY) && modon && IS_V6 && COMP_FIELD && (NIB_IDX == 2'h3)) begin
                w = oc_add(place(s.line_d[2], 2'h0) | place(s.line_d[1], 2'h1) | place(s.line_d[0], 2'h2)
                    | place(RXD, 2'h3), s.acc);
                next_s.line_d[3] = w[11:8];
                next_s.line_d[2] = w[15:12];
                next_s.line_d[1] = w[3:0];
                next_s.line_d[0] = w[7:4];
            end
        end
        if (emit) begin
            next_s.out_dv = 1'b1;
            next_s.out_d = s.line_d[7];
            next_s.out_er = s.line_e[7];
            if (s.line_b[7]) begin
                next_s.ocrc = crc4(s.ocrc, s.line_d[7]);
            end
        end
        if ((s.rx_st == ptpfp_pkg::R_DRAIN) && (s.fill != 4'h0)) begin
            next_s.line_d = {s.line_d[6:0], 4'h0};
            next_s.line_b = {s.line_b[6:0], 1'b0};
            next_s.line_e = {s.line_e[6:0], 1'b0};
            next_s.fill = s.fill - 4'h1;
            next_s.out_dv = 1'b1;
            // FCS recomputed only for modified frames.
            next_s.out_d = !s.mod ? s.line_d[7] : (s.fcs_ok ? ~s.ocrc[3:0] : s.ocrc[3:0]);
            next_s.ocrc = s.ocrc >> 4;
            // forced error on the last nibble, with counting.
            next_s.out_er = s.line_e[7] || ((s.fill == 4'h1) && (s.f_drop || s.f_filt));
            if (s.fill == 4'h1) begin
                next_s.filt_cnt = s.filt_cnt + {31'h0000_0000, s.f_filt};
                next_s.drop_cnt = s.drop_cnt + {31'h0000_0000, s.f_drop};
            end
        end

        // Transmit SFD watch and egress stamp.
        case (s.tx_st)
            ptpfp_pkg::T_IDLE: begin
                if (TX_EN && (TXD == `PTPFP_PREAMBLE)) begin
                    next_s.tx_st = ptpfp_pkg::T_PRE;
                end
            end
            ptpfp_pkg::T_PRE: begin
                if (!TX_EN) begin
                    next_s.tx_st = ptpfp_pkg::T_IDLE;
                end else if (TXD == `PTPFP_SFD) begin
                    next_s.ts = TOD + {16'h0000, s.lat};
                    next_s.ts_valid = 1'b1;
                    next_s.tx_st = ptpfp_pkg::T_BODY;
                end
            end
            ptpfp_pkg::T_BODY: begin
                if (!TX_EN) begin
                    next_s.tx_st = ptpfp_pkg::T_IDLE;
                end
            end
            default: next_s.tx_st = ptpfp_pkg::T_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs taken straight from the state register.
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign RXO_DV = s.out_dv;
    assign RXO_D = s.out_d;
    assign RXO_ER = s.out_er;
    assign EGRESS_TS = s.ts;
    assign EGRESS_VALID = s.ts_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour.
    a_apb_wait_one: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("APB answer not given after one wait state.");

    a_sfd_stamp_value: assert property (@(posedge CLK) disable iff (!NRST)
        (s.tx_st == ptpfp_pkg::T_PRE) && TX_EN && (TXD == `PTPFP_SFD)
        |=> EGRESS_VALID && (EGRESS_TS == $past(TOD) + {16'h0000, $past(s.lat)}))
        else $error("Egress stamp wrong at SFD.");

    a_filt_count_step: assert property (@(posedge CLK) disable iff (!NRST)
        (s.rx_st == ptpfp_pkg::R_DRAIN) && (s.fill == 4'h1) && s.f_filt
        |=> RXO_ER && (s.filt_cnt == $past(s.filt_cnt) + 32'h0000_0001))
        else $error("Filtered frame not marked or counted.");

    a_drop_count_step: assert property (@(posedge CLK) disable iff (!NRST)
        (s.rx_st == ptpfp_pkg::R_DRAIN) && (s.fill == 4'h1) && s.f_drop
        |=> RXO_ER && (s.drop_cnt == $past(s.drop_cnt) + 32'h0000_0001))
        else $error("Checksum drop not marked or counted.");

    a_er_same_place: assert property (@(posedge CLK) disable iff (!NRST)
        ((RX_DV && (s.rx_st != ptpfp_pkg::R_DRAIN) && (s.fill == 4'h8))
        || ((s.rx_st == ptpfp_pkg::R_DRAIN) && (s.fill != 4'h0))) && s.line_e[7]
        |=> RXO_DV && RXO_ER)
        else $error("Symbol error lost on its nibble.");

    a_fcs_untouched: assert property (@(posedge CLK) disable iff (!NRST)
        (s.rx_st == ptpfp_pkg::R_DRAIN) && (s.fill != 4'h0) && !s.mod
        |=> RXO_DV && (RXO_D == $past(s.line_d[7])))
        else $error("FCS altered on an unmodified frame.");

    a_fcs_bad_kept: assert property (@(posedge CLK) disable iff (!NRST)
        (s.rx_st == ptpfp_pkg::R_DRAIN) && (s.fill != 4'h0) && s.mod && !s.fcs_ok
        |=> RXO_D == $past(s.ocrc[3:0]))
        else $error("Bad original FCS not carried to output.");

    a_v4_ck_zero: assert property (@(posedge CLK) disable iff (!NRST)
        RX_DV && (s.rx_st == ptpfp_pkg::R_BODY) && PTP_QUAL && MOD_FRAME && IS_V4 && CK_FIELD
        && !MOD_VALID && s.ctrl[`PTPFP_MOD_EN] |=> s.line_d[0] == 4'h0)
        else $error("IPv4 checksum nibble not cleared.");
endmodule : ptpfp_top
`default_nettype wire

// ---- bench/ptpfp_phy_model.sv ----
/* Receive-side partner: sends preamble, SFD and body nibbles with the parser flags beside them.
 * Assumes the bench fills the nibble and flag arrays before it calls send. */
`timescale 1ns/1ps
`default_nettype none
module ptpfp_phy_model (
    input wire logic CLK,
    output logic RX_DV,
    output logic [3:0] RXD,
    output logic RX_ER,
    output logic PTP_QUAL,
    output logic CK_FIELD,
    output logic HDR_VALID,
    output logic MOD_VALID,
    output logic CK_COVER,
    output logic COMP_FIELD,
    output logic [1:0] NIB_IDX
);
    // Flag bits per nibble: 0 error, 1 qualified, 2 checksum field, 3 header, 4 substitute, 5 coverage, 6 compensation.
    logic [3:0] d [0:31];
    logic [6:0] f [0:31];
    // Lines start idle.
    initial begin
        {RX_DV, RX_ER, PTP_QUAL, CK_FIELD, HDR_VALID, MOD_VALID, CK_COVER, COMP_FIELD} = 8'h00;
        RXD = 4'h0;
        NIB_IDX = 2'h0;
    end
    // Sends one frame, then flips the idle bus every cycle so stale data never looks valid.
    task automatic send();
        int i;
        for (i = 0; i < 32; i++) begin
            @(posedge CLK);
            RX_DV <= 1'b1;
            RXD <= d[i];
            {COMP_FIELD, CK_COVER, MOD_VALID, HDR_VALID, CK_FIELD, PTP_QUAL, RX_ER} <= f[i];
            NIB_IDX <= i[1:0];
        end
        for (i = 0; i < 14; i++) begin
            @(posedge CLK);
            {COMP_FIELD, CK_COVER, MOD_VALID, HDR_VALID, CK_FIELD, PTP_QUAL, RX_ER, RX_DV} <= 8'h00;
            RXD <= ~RXD;
        end
    endtask : send
endmodule : ptpfp_phy_model
`default_nettype wire

// ---- bench/ptpfp_top_tb.sv ----
/* Self-checking bench of the frame processor: registers, receive fix-up and filtering, transmit stamp.
 * Assumes the receive partner model and the one-wait-state APB slave of the design. */
`include "ptpfp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin mismatches++; $display("MISMATCH %0t %s", $time, msg); end end
module ptpfp_top_tb;
    logic CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_DV, RX_ER, PTP_QUAL, IS_V4, IS_V6, MOD_FRAME;
    logic MOD_VALID, CK_COVER, CK_FIELD, COMP_FIELD, HDR_VALID, PTP_ALT_MASTER, RXO_DV, RXO_ER, TX_EN, EGRESS_VALID;
    logic [7:0] PADDR, PTP_DOMAIN, dom;
    logic [31:0] PWDATA, PRDATA, TOD, EGRESS_TS, rd, t;
    logic [3:0] RXD, MOD_NIB, PTP_MSG_TYPE, PTP_VERSION, RXO_D, TXD;
    logic [1:0] NIB_IDX;
    logic [15:0] mask, lat;
    logic [31:0] ctl [0:6];
    logic [3:0] qd [$];
    logic qe [$];
    logic er, fixck;
    int seed = 78979;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int exp_filt = 0;
    int i, k, n;
    ptpfp_top i_ptpfp_top (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_DV(RX_DV), .RXD(RXD), .RX_ER(RX_ER),
        .PTP_QUAL(PTP_QUAL), .IS_V4(IS_V4), .IS_V6(IS_V6), .MOD_FRAME(MOD_FRAME), .MOD_VALID(MOD_VALID),
        .MOD_NIB(MOD_NIB), .CK_COVER(CK_COVER), .CK_FIELD(CK_FIELD), .COMP_FIELD(COMP_FIELD), .NIB_IDX(NIB_IDX),
        .HDR_VALID(HDR_VALID), .PTP_MSG_TYPE(PTP_MSG_TYPE), .PTP_VERSION(PTP_VERSION), .PTP_DOMAIN(PTP_DOMAIN),
        .PTP_ALT_MASTER(PTP_ALT_MASTER), .RXO_DV(RXO_DV), .RXO_D(RXO_D), .RXO_ER(RXO_ER), .TX_EN(TX_EN),
        .TXD(TXD), .TOD(TOD), .EGRESS_TS(EGRESS_TS), .EGRESS_VALID(EGRESS_VALID));
    ptpfp_phy_model i_ptpfp_phy_model (.CLK(CLK), .RX_DV(RX_DV), .RXD(RXD), .RX_ER(RX_ER), .PTP_QUAL(PTP_QUAL),
        .CK_FIELD(CK_FIELD), .HDR_VALID(HDR_VALID), .MOD_VALID(MOD_VALID), .CK_COVER(CK_COVER),
        .COMP_FIELD(COMP_FIELD), .NIB_IDX(NIB_IDX));
    ////////////////////////////////////////
    // Clock of 4 ns and a time-of-day count that wraps soon.
    always #2 CLK = ~CLK;
    always @(posedge CLK) TOD <= TOD + 32'h0000_0007;
    // Collects the output stream and cuts a hang short.
    always @(posedge CLK) begin
        if (RXO_DV === 1'b1) begin
            qd.push_back(RXO_D);
            qe.push_back(RXO_ER);
        end
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // One's-complement sum of the words in nibbles 8 to 23, high byte first, low nibble first in a byte.
    function automatic logic [15:0] ocsum(input logic [3:0] v [0:31]);
        logic [31:0] a;
        a = 32'h0000_0000;
        for (int w = 8; w < 24; w += 4) begin
            a = a + {16'h0000, v[w + 1], v[w], v[w + 3], v[w + 2]};
        end
        a = {16'h0000, a[15:0]} + {16'h0000, a[31:16]};
        return a[15:0] + a[31:16];
    endfunction : ocsum
    // Ethernet CRC register over nibbles 8 up to last, lowest bit of each nibble first.
    function automatic logic [31:0] crc_run(input logic [3:0] v [0:31], input int last);
        logic [31:0] c;
        c = `PTPFP_CRC_INIT;
        for (int j = 8; j <= last; j++) begin
            for (int b = 0; b < 4; b++) begin
                c = (c >> 1) ^ ((c[0] ^ v[j][b]) ? `PTPFP_POLY : 32'h0000_0000);
            end
        end
        return c;
    endfunction : crc_run
    // One APB transfer; holds the request until ready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        `CHK(PREADY, 1'b1, "no ready")
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, exp, "read data")
        `CHK(er, 1'b0, "read error")
    endtask : rchk
    // Builds a random frame, works out the expected stream, sends it and compares.
    // With fixck set the frame has a good FCS, a good UDP checksum and a compensation word at 20 to 23.
    task automatic run_frame(input logic q, input logic modded, input logic forced, input logic ckz);
        logic [3:0] ed [0:31];
        logic [3:0] od [0:31];
        logic ee [0:31];
        logic [31:0] c;
        int j;
        for (j = 0; j < 32; j++) begin
            od[j] = (j < 7) ? 4'h5 : (j == 7) ? 4'hD : 4'($random(seed));
            if ((ckz || fixck) && j >= 12 && j < 16) od[j] = 4'h0;
            i_ptpfp_phy_model.f[j] = {fixck && j >= 20 && j < 24, fixck && j > 7 && j < 24, j == 18, j == 10,
                j >= 12 && j < 16, q && j > 7, j > 7 && j < 24 && ($random(seed) % 8 == 0)};
        end
        // Checksum word that brings the covered sum to all ones, then a good FCS behind the body.
        if (fixck) begin
            c = {16'h0000, ~ocsum(od)};
            {od[13], od[12], od[15], od[14]} = c[15:0];
            c = crc_run(od, 23);
            for (j = 0; j < 8; j++) od[24 + j] = ~c[4 * j +: 4];
        end
        i_ptpfp_phy_model.d = od;
        for (j = 0; j < 32; j++) begin
            ed[j] = (modded && j == 18) ? MOD_NIB : (modded && IS_V4 && j >= 12 && j < 16) ? 4'h0 : od[j];
            ee[j] = i_ptpfp_phy_model.f[j][0] | (forced && j == 31);
        end
        qd.delete();
        qe.delete();
        i_ptpfp_phy_model.send();
        `CHK(qd.size(), 32, "frame length")
        for (j = 0; j < 32 && j < qd.size(); j++) begin
            od[j] = qd[j];
            if (j < 20 || (j < 24 && !fixck) || !modded) `CHK(qd[j], ed[j], "nibble")
            `CHK(qe[j], ee[j], "symbol error")
        end
        if (modded) `CHK(crc_run(od, 31) == `PTPFP_RESIDUE, fixck, "output FCS")
        if (fixck) `CHK(ocsum(od), 16'hFFFF, "output checksum")
    endtask : run_frame
    ////////////////////////////////////////
    // Main sequence.
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, IS_V4, IS_V6, MOD_FRAME, fixck, PTP_ALT_MASTER, TX_EN} = 10'h000;
        {PADDR, PTP_DOMAIN, PWDATA, MOD_NIB, PTP_MSG_TYPE, PTP_VERSION, TXD} = 64'h0;
        CLK = 1'b0;
        TOD = 32'hFFFF_FF00;
        repeat (3) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        // Reset values, unmapped place, read-only place and control field widths.
        for (i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000);
        `CHK(er, 1'b1, "unmapped error")
        `CHK(rd, 32'h0000_0000, "unmapped data")
        apb(1'b1, `PTPFP_OFS_FILT, 32'hFFFF_FFFF);
        rchk(`PTPFP_OFS_FILT, 32'h0000_0000);
        apb(1'b1, `PTPFP_OFS_CTRL, 32'hFFFF_FFFF);
        rchk(`PTPFP_OFS_CTRL, 32'h00FF_0FFF);
        for (k = 0; k < 4; k++) begin
            lat = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h005F : 16'($random(seed));
            apb(1'b1, `PTPFP_OFS_LAT, {16'h0000, lat});
            for (i = 0; i < 8; i++) begin
                TX_EN <= 1'b1;
                TXD <= (i == 7) ? 4'hD : 4'h5;
                @(posedge CLK);
            end
            t = TOD;
            TX_EN <= 1'b0;
            TXD <= 4'h2;
            n = 0;
            do begin
                @(posedge CLK);
                n++;
            end while (EGRESS_VALID !== 1'b1 && n < 4);
            `CHK(n, 1, "egress delay")
            `CHK(EGRESS_TS, t + {16'h0000, lat}, "egress stamp")
            rchk(`PTPFP_OFS_TS, t + {16'h0000, lat});
        end
        mask = 16'($random(seed));
        mask[0] = 1'b1;
        mask[1] = 1'b0;
        apb(1'b1, `PTPFP_OFS_MASK, {16'h0000, mask});
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0021);
        for (k = 0; k < 16; k++) begin
            PTP_MSG_TYPE <= 4'(k);
            run_frame(1'b1, 1'b0, mask[k], 1'b0);
            exp_filt += int'(mask[k]);
        end
        dom = 8'($random(seed));
        PTP_DOMAIN <= dom;
        PTP_VERSION <= 4'h2;
        ctl = '{32'h0000_0225, 32'h0000_0325, 32'h0000_0025, {8'h00, dom, 16'h0029}, {8'h00, dom ^ 8'h01, 16'h0029},
            32'h0000_0031, 32'h0000_0031};
        apb(1'b1, `PTPFP_OFS_MASK, 32'h0000_0000);
        for (k = 0; k < 7; k++) begin
            apb(1'b1, `PTPFP_OFS_CTRL, ctl[k]);
            PTP_ALT_MASTER <= (k == 5);
            run_frame(1'b1, 1'b0, k == 1 || k == 4 || k == 5, 1'b0);
            exp_filt += int'(k == 1 || k == 4 || k == 5);
        end
        apb(1'b1, `PTPFP_OFS_MASK, 32'h0000_FFFF);
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0021);
        run_frame(1'b0, 1'b0, 1'b0, 1'b0);
        rchk(`PTPFP_OFS_FILT, 32'(exp_filt));
        MOD_FRAME <= 1'b1;
        MOD_NIB <= 4'($random(seed));
        IS_V6 <= 1'b1;
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0002);
        run_frame(1'b1, 1'b1, 1'b1, 1'b1);
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0082);
        run_frame(1'b1, 1'b1, 1'b0, 1'b1);
        // valid IPv6 checksum is kept by compensation
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0002);
        fixck = 1'b1;
        run_frame(1'b1, 1'b1, 1'b0, 1'b0);
        fixck = 1'b0;
        IS_V6 <= 1'b0;
        IS_V4 <= 1'b1;
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0002);
        run_frame(1'b1, 1'b1, 1'b0, 1'b1);
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0042);
        run_frame(1'b1, 1'b1, 1'b0, 1'b0);
        apb(1'b1, `PTPFP_OFS_CTRL, 32'h0000_0000);
        run_frame(1'b1, 1'b0, 1'b0, 1'b0);
        rchk(`PTPFP_OFS_DROP, 32'h0000_0001);
        rchk(`PTPFP_OFS_FILT, 32'(exp_filt));
        print_verdict();
    end
endmodule : ptpfp_top_tb
`undef CHK
`default_nettype wire
